// ==== hw/cbt_unit.v ====
// Operation
// - Decode branch_negative_likely: opcode 000001, field b 00010, 16-bit offset.
// - Target is delay-slot address plus sign-extended offset shifted by two.
// - branch_negative_likely taken when source_register_a sign bit is set.
// - Likely branch not taken squashes the delay slot, continues sequentially.
// - Condition computed at the branch; redirect or squash in delay slot.
// - Decode branch_unequal: opcode 000101, two source fields, 16-bit offset.
// - branch_unequal taken when sources differ; delay slot always executes.
// - Opcode 010101 is branch_unequal_likely; squashes slot when not taken.
// - Decode debug trap: opcode 000000, function 001101, code field ignored.
// - Debug trap raises a breakpoint exception at once, unconditionally.
// - Trap code field is never passed to the handler through a register.
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defs.vh"

module cbt_unit (
  // Clock and reset
  input wire clock_i,
  input wire reset_n_i,
  input wire clk_en_i,
  // Execute stage
  input wire exec_valid_i,
  input wire [31:0] exec_instr_i,
  input wire [31:0] exec_pc_i,
  input wire [31:0] source_register_a_i,
  input wire [31:0] source_register_b_i,
  // Redirect and squash, delay-slot time
  output reg redirect_o,
  output reg [31:0] redirect_target_o,
  output reg squash_delay_slot_o,
  // Exception
  output wire breakpoint_o
);

  reg rst_meta;
  reg rst_sync;
  reg pending;
  reg pend_taken;
  reg pend_likely;
  reg [31:0] pend_target;
  wire [1:0] kind;
  wire trap_hit;
  reg cond;
  wire [31:0] target;

  function [31:0] branch_target;
    input [31:0] pc;
    input [15:0] off;
    begin
      branch_target = pc + `CBT_PC_STEP +
        {{14{off[15]}}, off, 2'b00};
    end
  endfunction

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  cbt_decoder u_dec (
    .instr_i(exec_instr_i),
    .kind_o(kind),
    .trap_o(trap_hit)
  );

  assign target = branch_target(exec_pc_i,
    exec_instr_i[`CBT_OFF_HI:`CBT_OFF_LO]);

  always @* begin
    cond = 1'b0;
    case (kind)
      `CBT_KIND_NEGL: cond = source_register_a_i[`CBT_SIGN_BIT];
      `CBT_KIND_UNEQ: cond = source_register_a_i != source_register_b_i;
      `CBT_KIND_UNEQL: cond = source_register_a_i != source_register_b_i;
      default: cond = 1'b0;
    endcase
  end

  // Immediate, combinational so the handler is entered without delay
  // only the event leaves, never the code field
  assign breakpoint_o = exec_valid_i & trap_hit & clk_en_i & rst_sync;

  // Capture at the branch, act one instruction later
  // Assumes the slot holds no branch
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pending <= 1'b0;
      pend_taken <= 1'b0;
      pend_likely <= 1'b0;
      pend_target <= 32'h00000000;
    end else if (!rst_sync) begin
      pending <= 1'b0;
      pend_taken <= 1'b0;
      pend_likely <= 1'b0;
      pend_target <= 32'h00000000;
    end else if (clk_en_i && exec_valid_i) begin
      pending <= (kind != `CBT_KIND_NONE) && !trap_hit;
      pend_taken <= cond;
      pend_likely <= (kind == `CBT_KIND_NEGL) ||
        (kind == `CBT_KIND_UNEQL);
      pend_target <= target;
    end
  end

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      redirect_o <= 1'b0;
      redirect_target_o <= 32'h00000000;
      squash_delay_slot_o <= 1'b0;
    end else if (!rst_sync) begin
      redirect_o <= 1'b0;
      redirect_target_o <= 32'h00000000;
      squash_delay_slot_o <= 1'b0;
    end else if (clk_en_i && exec_valid_i) begin
      // Taken: redirect after the slot
      redirect_o <= pending & pend_taken;
      redirect_target_o <= pend_target;
      // Untaken likely squashes; plain untaken does nothing
      squash_delay_slot_o <= pending & ~pend_taken & pend_likely;
    end else if (clk_en_i) begin
      redirect_o <= 1'b0;
      squash_delay_slot_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== hw/cbt_defs.vh ====
`ifndef CBT_DEFS_VH
`define CBT_DEFS_VH

// Instruction word fields
`define CBT_OP_HI 31
`define CBT_OP_LO 26
`define CBT_SRCA_HI 25
`define CBT_SRCA_LO 21
`define CBT_SRCB_HI 20
`define CBT_SRCB_LO 16
`define CBT_OFF_HI 15
`define CBT_OFF_LO 0
`define CBT_FUNC_HI 5
`define CBT_FUNC_LO 0
`define CBT_SIGN_BIT 31

// Major opcodes and sub-codes
`define CBT_OP_SPECIAL 6'h00
`define CBT_OP_REGISTER_IMMEDIATE_GROUP 6'h01
`define CBT_OP_UNEQUAL 6'h05
`define CBT_OP_UNEQUAL_LIKELY 6'h15
`define CBT_RI_NEG_LIKELY 5'h02
`define CBT_FN_TRAP 6'h0d

// Kinds of decoded instruction
`define CBT_KIND_NONE 2'h0
`define CBT_KIND_NEGL 2'h1
`define CBT_KIND_UNEQ 2'h2
`define CBT_KIND_UNEQL 2'h3

// Address step to the delay-slot instruction
`define CBT_PC_STEP 32'h00000004

`endif

// ==== hw/cbt_decoder.v ====
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defs.vh"

module cbt_decoder (
  // Instruction
  input wire [31:0] instr_i,
  // Decode results
  output reg [1:0] kind_o,
  output wire trap_o
);

  wire [5:0] op;
  wire [4:0] sub;
  wire [5:0] fn;

  assign op = instr_i[`CBT_OP_HI:`CBT_OP_LO];
  assign sub = instr_i[`CBT_SRCB_HI:`CBT_SRCB_LO];
  assign fn = instr_i[`CBT_FUNC_HI:`CBT_FUNC_LO];

  // Code field is not looked at
  assign trap_o = (op == `CBT_OP_SPECIAL) && (fn == `CBT_FN_TRAP);

  always @* begin
    kind_o = `CBT_KIND_NONE;
    if (op == `CBT_OP_REGISTER_IMMEDIATE_GROUP && sub == `CBT_RI_NEG_LIKELY) begin
      kind_o = `CBT_KIND_NEGL;
    end else if (op == `CBT_OP_UNEQUAL) begin
      kind_o = `CBT_KIND_UNEQ;
    end else if (op == `CBT_OP_UNEQUAL_LIKELY) begin
      kind_o = `CBT_KIND_UNEQL;
    end
  end

endmodule
`default_nettype wire

// ==== verification/cbt_unit_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbt_unit_asserts (
  input wire logic clock_i, reset_n_i, clk_en_i, exec_valid_i,
  input wire logic [31:0] exec_instr_i, exec_pc_i,
  input wire logic [31:0] source_register_a_i, source_register_b_i,
  input wire logic redirect_o, squash_delay_slot_o, breakpoint_o,
  input wire logic [31:0] redirect_target_o
);
  wire logic [5:0] op = exec_instr_i[31:26];
  wire logic go = clk_en_i && exec_valid_i;
  wire logic ng = op == 6'h01 && exec_instr_i[20:16] == 5'h02;
  wire logic ne = op == 6'h05 || op == 6'h15;
  wire logic tr = op == 6'h00 && exec_instr_i[5:0] == 6'h0d;
  logic pv, cd, lk;
  logic [31:0] pt;
  // A slot is never itself a branch, so a pending branch ends at the slot
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) pv <= 1'b0;
    else if (go) begin
      pv <= !pv && (ng || ne);
      cd <= ng ? source_register_a_i[31] : source_register_a_i != source_register_b_i;
      lk <= op != 6'h05;
      pt <= exec_pc_i + 32'h4 + {{14{exec_instr_i[15]}}, exec_instr_i[15:0], 2'h0};
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  a_trap_fires: assert property (go && tr |-> breakpoint_o)
    else $error("breakpoint missing");
  a_trap_cause: assert property (breakpoint_o |-> go && tr)
    else $error("breakpoint without trap");
  a_taken_target: assert property (pv && go && cd |=> redirect_o &&
    !squash_delay_slot_o && redirect_target_o == $past(pt)) else $error("bad redirect");
  a_likely_squash: assert property (pv && go && !cd && lk |=>
    squash_delay_slot_o && !redirect_o) else $error("slot not squashed");
  a_plain_runs: assert property (pv && go && !cd && !lk |=>
    !squash_delay_slot_o && !redirect_o) else $error("plain branch acted");
  a_redir_pulse: assert property (redirect_o && clk_en_i |=> !redirect_o)
    else $error("redirect too long");
  a_squash_pulse: assert property (squash_delay_slot_o && clk_en_i |=>
    !squash_delay_slot_o) else $error("squash too long");
  a_event_cause: assert property (!(pv && go) |=> !$rose(redirect_o) &&
    !$rose(squash_delay_slot_o)) else $error("event without slot");
  cover property (redirect_o);
  cover property (squash_delay_slot_o);
  cover property (breakpoint_o);
endmodule
`default_nettype wire

// ==== verification/cbt_pipe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbt_pipe_model (
  input wire logic clock_i, redirect_i,
  input wire logic [31:0] target_i,
  output logic en_o, vld_o,
  output logic [31:0] ins_o, pc_o, ra_o, rb_o
);
  initial {en_o, vld_o, ins_o, pc_o, ra_o, rb_o} = {2'h2, 128'h0, 32'h100, 64'h0};
  // Fetch follows a redirect only after the slot was taken
  task issue(input logic [31:0] ins, a, b, input logic v, en);
    @(negedge clock_i);
    if (vld_o && en_o) pc_o = redirect_i ? target_i : pc_o + 32'h4;
    {vld_o, en_o, ins_o, ra_o, rb_o} = {v, en, ins, a, b};
  endtask
endmodule
`default_nettype wire

// ==== verification/cbt_unit_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbt_unit_tb_top;
  logic clock_i = 0, reset_n_i = 0;
  logic redirect_o, squash_delay_slot_o, breakpoint_o, en, vld;
  logic [31:0] redirect_target_o, ins, pc, ra, rb;
  int n_fail = 0, n_tests = 0;
  logic [34:0] q[$];
  always #25 clock_i = ~clock_i;
  cbt_pipe_model pm_u (.clock_i, .redirect_i(redirect_o),
    .target_i(redirect_target_o), .en_o(en), .vld_o(vld), .ins_o(ins),
    .pc_o(pc), .ra_o(ra), .rb_o(rb));
  cbt_unit dut_u (.clock_i, .reset_n_i, .clk_en_i(en), .exec_valid_i(vld),
    .exec_instr_i(ins), .exec_pc_i(pc), .source_register_a_i(ra),
    .source_register_b_i(rb), .redirect_o, .redirect_target_o,
    .squash_delay_slot_o, .breakpoint_o);
  task end_sim;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [34:0] s);
    logic [34:0] e;
    e = q.size() ? q.pop_front() : 35'h0;
    n_tests++;
    if (e !== s) begin
      n_fail++;
      $display("MISMATCH event exp %h got %h", e, s);
    end
  endtask
  // Branch notes precede a trap note seen at the same edge
  always @(posedge clock_i) if (en === 1'b1) begin
    if ((redirect_o | squash_delay_slot_o) !== 1'b0) chk({redirect_o,
      squash_delay_slot_o, 1'b0, redirect_o ? redirect_target_o : 32'h0});
    if (breakpoint_o !== 1'b0) chk({3'b001, 32'h0});
  end
  initial begin
    #200000 n_fail++;
    end_sim;
  end
  initial begin
    logic [31:0] a, b, w, t;
    int k;
    void'($urandom(32'h0886));
    repeat (8) @(posedge clock_i);
    @(negedge clock_i) reset_n_i = 1;
    repeat (2) @(posedge clock_i);
    repeat (300) begin
      k = $urandom % 6;
      a = $urandom;
      b = k[0] ? a : $urandom;
      w = $urandom;
      w[31:26] = k == 1 ? 6'h05 : k == 2 ? 6'h15 : k > 2 && k != 4 ? 6'h00 : 6'h01;
      if (k == 0 || k == 4) w[20:16] = k == 0 ? 5'h02 : 5'h00;
      if (k == 3 || k == 5) w[5:0] = 6'h0d;
      pm_u.issue(w, a, b, 1'b1, k != 5);
      t = pm_u.pc_o + 32'h4 + {{14{w[15]}}, w[15:0], 2'h0};
      if (k < 3 && (k == 0 ? a[31] : a != b)) q.push_back({3'b100, t});
      else if (k == 0 || k == 2) q.push_back(35'h200000000);
      if (k == 3) q.push_back(35'h100000000);
      // Slot is a plain word, never a branch
      if (k < 3) pm_u.issue(32'h0, a, b, 1'b1, 1'b1);
      if ($urandom % 2) pm_u.issue($urandom, b, a, 1'b0, 1'b1);
    end
    repeat (4) @(posedge clock_i);
    n_tests++;
    if (q.size() != 0) n_fail++;
    end_sim;
  end
endmodule
bind cbt_unit cbt_unit_asserts ck_u (.clock_i, .reset_n_i, .clk_en_i,
  .exec_valid_i, .exec_instr_i, .exec_pc_i, .source_register_a_i,
  .source_register_b_i, .redirect_o, .squash_delay_slot_o, .breakpoint_o,
  .redirect_target_o);
`default_nettype wire
